//--- rtl/eib_pkg.sv
// Summary of operation
// [R01] Select bits 7:5 = 001 and bits 3:0 = 0 route access to EEE global space.
// [R02] Select bits 3:0 holding 1 to 4 route access to that port's EEE set.
// [R03] Offset register picks the byte; data moves through indirect byte register 0xA0.
// [R04] Each 16-bit register spans two offsets: even is high byte, odd low byte.
// [R05] Wakeup threshold reads 0x0201; longer PHY wakeups increment the error counter.
// [R06] Min_lpi_cycles_control register at 0x36/0x37 is reserved and reads 0x0000.
// [R07] PCS diagnostic register at 0x3A/0x3B is reserved and reads 0x0001.
// [R08] Per-port expansion status at 0x0C/0x0D; bits 15 to 7 reserved zero.
// [R09] Status bit 6 reads 1: next page location given by bits 6 to 5.
// [R10] Status bit 5 shows next pages stored in register 8h; resets to 1.
// [R11] Bit 4 sets on parallel detection fault, clears when read, resets 0.
// [R12] Bit 3 shows link partner next page ability, resets 0.
// [R13] Bit 2 shows local next page ability, reads 1.
// [R14] Bit 1 latches high on new page received until read, resets 0.
// [R15] Bit 0 shows link partner auto-negotiation ability, resets 0.
// [R16] EEE registers exist only for the copper ports, globally and per port.
// [R17] Host writes select first, then offset; offset write triggers the access.
// [R18] Writes to read-only or reserved EEE fields are ignored.
package eib_pkg;

	localparam int EIB_NUM_PORTS = 4;

	localparam logic [7:0] EIB_SEL_ADDR = 8'h6E;
	localparam logic [7:0] EIB_OFS_ADDR = 8'h6F;
	localparam logic [7:0] EIB_DATA_ADDR = 8'hA0;

	localparam logic [2:0] EIB_SPACE_EEE = 3'h1;
	localparam logic [3:0] EIB_TGT_GLOBAL = 4'h0;
	localparam logic [3:0] EIB_PORT_FIRST = 4'h1;
	localparam logic [3:0] EIB_PORT_LAST = 4'h4;

	localparam logic [7:0] EIB_OFS_MIN_LPI = 8'h36;
	localparam logic [7:0] EIB_OFS_WAKE_THR = 8'h38;
	localparam logic [7:0] EIB_OFS_PCS_DIAG = 8'h3A;
	localparam logic [7:0] EIB_OFS_AN_EXP = 8'h0C;

	localparam logic [15:0] EIB_MIN_LPI_RST = 16'h0000;
	localparam logic [15:0] EIB_WAKE_THR_RST = 16'h0201;
	localparam logic [15:0] EIB_PCS_DIAG_RST = 16'h0001;

	localparam logic [7:0] EIB_SEL_RST = 8'h00;
	localparam logic [7:0] EIB_OFS_RST = 8'h00;
	localparam logic [7:0] EIB_DATA_RST = 8'h00;

	localparam int EIB_BIT_LOC_ABLE = 6;
	localparam int EIB_BIT_LOC_8H = 5;
	localparam int EIB_BIT_PD_FAULT = 4;
	localparam int EIB_BIT_LP_NP = 3;
	localparam int EIB_BIT_NP_ABLE = 2;
	localparam int EIB_BIT_PAGE_RX = 1;
	localparam int EIB_BIT_LP_AN = 0;
	localparam logic EIB_LOC_ABLE_RST = 1'b1;
	localparam logic EIB_LOC_8H_RST = 1'b1;
	localparam logic EIB_NP_ABLE_RST = 1'b1;

	localparam int EIB_CLK_PERIOD_PS = 8000;
	localparam int EIB_WAKE_UNIT_NS = 1;
	localparam int EIB_WAKE_UNIT_CYC_INT = (EIB_WAKE_UNIT_NS * 1000 + EIB_CLK_PERIOD_PS - 1)
		/ EIB_CLK_PERIOD_PS;
	localparam logic [7:0] EIB_WAKE_UNIT_CYC = 8'(EIB_WAKE_UNIT_CYC_INT);

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} eib_req_type;

	typedef struct packed {
		logic pd_fault;
		logic page_rx;
		logic lp_np_able;
		logic lp_an_able;
		logic wake_start;
		logic wake_done;
	} eib_phy_type;

	function automatic logic [7:0] eib_byte_sel(input logic [15:0] value, input logic odd);
		eib_byte_sel = odd ? value[7:0] : value[15:8];
	endfunction

	function automatic logic eib_is_port(input logic [3:0] tgt);
		eib_is_port = (tgt >= EIB_PORT_FIRST) && (tgt <= EIB_PORT_LAST);
	endfunction

endpackage

//--- rtl/eib_port_stat.sv
`timescale 1ns/1ps
module eib_port_stat (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire eib_pkg::eib_phy_type phy_i,
	input wire logic rd_clr_i,
	output logic [15:0] status_o
);
	import eib_pkg::*;

	typedef struct packed {
		logic pd_fault;
		logic page_rx;
		logic lp_np;
		logic lp_an;
	} eib_pstat_type;

	eib_pstat_type st_ff;
	eib_pstat_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (rd_clr_i) begin
			nxt_st.pd_fault = 1'b0; // R11
			nxt_st.page_rx = 1'b0; // R14
		end
		if (phy_i.pd_fault) begin
			nxt_st.pd_fault = 1'b1; // R11
		end
		if (phy_i.page_rx) begin
			nxt_st.page_rx = 1'b1; // R14
		end
		nxt_st.lp_np = phy_i.lp_np_able; // R12
		nxt_st.lp_an = phy_i.lp_an_able; // R15
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_comb begin
		status_o = 16'h0000; // R08
		status_o[EIB_BIT_LOC_ABLE] = EIB_LOC_ABLE_RST; // R09
		status_o[EIB_BIT_LOC_8H] = EIB_LOC_8H_RST; // R10
		status_o[EIB_BIT_PD_FAULT] = st_ff.pd_fault; // R11
		status_o[EIB_BIT_LP_NP] = st_ff.lp_np; // R12
		status_o[EIB_BIT_NP_ABLE] = EIB_NP_ABLE_RST; // R13
		status_o[EIB_BIT_PAGE_RX] = st_ff.page_rx; // R14
		status_o[EIB_BIT_LP_AN] = st_ff.lp_an; // R15
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	AST_PAGE_LATCH: assert property (phy_i.page_rx |=> status_o[1] == 1'b1) // R14
		else $error("page received not latched");
	AST_PAGE_HOLD: assert property (status_o[1] && !rd_clr_i |=> status_o[1]) // R14
		else $error("page received dropped before read");
	AST_PAGE_CLR: assert property (rd_clr_i && !phy_i.page_rx |=> !status_o[1]) // R14
		else $error("page received not cleared by read");
	AST_PD_SET: assert property (phy_i.pd_fault |=> status_o[4]) // R11
		else $error("parallel detection fault not set");
	AST_PD_CLR: assert property (rd_clr_i && !phy_i.pd_fault |=> !status_o[4]) // R11
		else $error("parallel detection fault not cleared by read");
	AST_LP_FOLLOW: assert property (##1 status_o[3] == $past(phy_i.lp_np_able) // R12 R15
		&& status_o[0] == $past(phy_i.lp_an_able))
		else $error("link partner ability bits do not follow");

endmodule // eib_port_stat

//--- rtl/eib_wake_mon.sv
`timescale 1ns/1ps
module eib_wake_mon (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [15:0] threshold_i,
	input wire logic wake_start_i,
	input wire logic wake_done_i,
	output logic [15:0] err_cnt_o
);
	import eib_pkg::*;

	typedef struct packed {
		logic busy;
		logic flagged;
		logic [7:0] tick;
		logic [15:0] units;
		logic [15:0] err_cnt;
	} eib_wake_type;

	eib_wake_type st_ff;
	eib_wake_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (wake_start_i) begin
			nxt_st.busy = 1'b1;
			nxt_st.flagged = 1'b0;
			nxt_st.tick = 8'h00;
			nxt_st.units = 16'h0000;
		end else if (st_ff.busy) begin
			if (wake_done_i) begin
				nxt_st.busy = 1'b0;
			end
			if (st_ff.tick == EIB_WAKE_UNIT_CYC - 8'h01) begin
				nxt_st.tick = 8'h00;
				if (st_ff.units != 16'hFFFF) begin
					nxt_st.units = st_ff.units + 16'h0001;
				end
			end else begin
				nxt_st.tick = st_ff.tick + 8'h01;
			end
			if (st_ff.units > threshold_i && !st_ff.flagged) begin
				nxt_st.flagged = 1'b1; // R05
				if (st_ff.err_cnt != 16'hFFFF) begin
					nxt_st.err_cnt = st_ff.err_cnt + 16'h0001; // R05
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign err_cnt_o = st_ff.err_cnt;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	AST_ERR_STEP: assert property (err_cnt_o != $past(err_cnt_o) // R05
		|-> err_cnt_o == $past(err_cnt_o) + 16'h0001)
		else $error("wakeup error count moved by other than one");
	AST_ERR_CAUSE: assert property (err_cnt_o != $past(err_cnt_o) // R05
		|-> $past(st_ff.units) > $past(threshold_i))
		else $error("wakeup error counted without exceeding threshold");

endmodule // eib_wake_mon

//--- rtl/eib_bank.sv
`timescale 1ns/1ps
module eib_bank (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire eib_pkg::eib_req_type req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	input wire eib_pkg::eib_phy_type [eib_pkg::EIB_NUM_PORTS-1:0] phy_i,
	output logic [eib_pkg::EIB_NUM_PORTS-1:0][15:0] wake_err_cnt_o
);
	import eib_pkg::*;

	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] ofs;
		logic [7:0] data;
		logic [7:0] rdata;
		logic rvalid;
	} eib_bank_type;

	eib_bank_type st_ff;
	eib_bank_type nxt_st;

	logic [EIB_NUM_PORTS-1:0][15:0] port_status;
	logic [EIB_NUM_PORTS-1:0] port_rd_clr;
	logic [15:0] wake_threshold;

	logic sel_wr;
	logic ofs_wr;
	logic data_wr;
	logic eee_space;
	logic eee_global;
	logic eee_port;
	logic [1:0] port_idx;

	// The threshold is a fixed standard value; software cannot change it.
	assign wake_threshold = EIB_WAKE_THR_RST; // R05

	assign sel_wr = req_i.wr && req_i.addr == EIB_SEL_ADDR;
	assign ofs_wr = req_i.wr && req_i.addr == EIB_OFS_ADDR;
	assign data_wr = req_i.wr && req_i.addr == EIB_DATA_ADDR;

	// Routing uses the select value already stored; the offset write triggers the access.
	assign eee_space = st_ff.sel[7:5] == EIB_SPACE_EEE; // R01
	assign eee_global = eee_space && st_ff.sel[3:0] == EIB_TGT_GLOBAL; // R01
	assign eee_port = eee_space && eib_is_port(st_ff.sel[3:0]); // R02 R16
	assign port_idx = 2'(st_ff.sel[3:0] - EIB_PORT_FIRST); // R02

	// Byte fetch for the global EEE space.
	function automatic logic [7:0] eib_global_byte(input logic [7:0] ofs);
		logic [7:0] res;
		res = 8'h00;
		case ({ofs[7:1], 1'b0})
			EIB_OFS_MIN_LPI: begin
				res = eib_byte_sel(EIB_MIN_LPI_RST, ofs[0]); // R06
			end
			EIB_OFS_WAKE_THR: begin
				res = eib_byte_sel(wake_threshold, ofs[0]); // R04 R05
			end
			EIB_OFS_PCS_DIAG: begin
				res = eib_byte_sel(EIB_PCS_DIAG_RST, ofs[0]); // R07
			end
			default: begin
				res = 8'h00;
			end
		endcase
		return res;
	endfunction

	// Byte fetch for one copper port's EEE set.
	function automatic logic [7:0] eib_port_byte(input logic [7:0] ofs, input logic [15:0] stat);
		logic [7:0] res;
		res = 8'h00;
		if ({ofs[7:1], 1'b0} == EIB_OFS_AN_EXP) begin
			res = eib_byte_sel(stat, ofs[0]); // R04 R08
		end
		return res;
	endfunction

	// A trigger on the odd offset returns the low status byte, which counts as a read.
	always_comb begin
		port_rd_clr = '0;
		if (ofs_wr && eee_port && req_i.wdata == (EIB_OFS_AN_EXP | 8'h01)) begin
			port_rd_clr[port_idx] = 1'b1; // R11 R14
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rvalid = 1'b0;
		if (sel_wr) begin
			nxt_st.sel = req_i.wdata; // R17
		end
		if (ofs_wr) begin
			nxt_st.ofs = req_i.wdata; // R03
			if (eee_global) begin
				nxt_st.data = eib_global_byte(req_i.wdata); // R01 R03
			end else if (eee_port) begin
				nxt_st.data = eib_port_byte(req_i.wdata, port_status[port_idx]); // R02 R03
			end else begin
				nxt_st.data = 8'h00; // R16
			end
		end
		// Every EEE field is read-only, so data writes in EEE space leave it unchanged; writes outside EEE space are stored.
		if (data_wr && !eee_space) begin // R18
			nxt_st.data = req_i.wdata;
		end
		if (req_i.rd) begin
			nxt_st.rvalid = 1'b1;
			case (req_i.addr)
				EIB_SEL_ADDR: begin
					nxt_st.rdata = st_ff.sel;
				end
				EIB_OFS_ADDR: begin
					nxt_st.rdata = st_ff.ofs;
				end
				EIB_DATA_ADDR: begin
					nxt_st.rdata = st_ff.data; // R03
				end
				default: begin
					nxt_st.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_ff.sel <= EIB_SEL_RST;
			st_ff.ofs <= EIB_OFS_RST;
			st_ff.data <= EIB_DATA_RST;
			st_ff.rdata <= 8'h00;
			st_ff.rvalid <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata_o = st_ff.rdata;
	assign rvalid_o = st_ff.rvalid;

	for (genvar p = 0; p < EIB_NUM_PORTS; p++) begin : g_port
		eib_port_stat u_stat (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.phy_i(phy_i[p]),
			.rd_clr_i(port_rd_clr[p]),
			.status_o(port_status[p])
		);

		eib_wake_mon u_wake (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.threshold_i(wake_threshold),
			.wake_start_i(phy_i[p].wake_start),
			.wake_done_i(phy_i[p].wake_done),
			.err_cnt_o(wake_err_cnt_o[p])
		);
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_trig_global(logic [7:0] ofs);
		ofs_wr && eee_global && !sel_wr && req_i.wdata == ofs;
	endsequence

	sequence s_trig_port(logic [7:0] ofs);
		ofs_wr && eee_port && !sel_wr && req_i.wdata == ofs;
	endsequence

	sequence s_read_data;
		req_i.rd && req_i.addr == EIB_DATA_ADDR;
	endsequence

	sequence s_read_at(logic [7:0] reg_addr);
		req_i.rd && req_i.addr == reg_addr;
	endsequence

	sequence s_idle_data;
		!ofs_wr && !data_wr;
	endsequence

	AST_WAKE_HI: assert property (s_trig_global(8'h38) |=> st_ff.data == 8'h02) // R04
		else $error("wakeup threshold high byte wrong");
	AST_WAKE_LO: assert property (s_trig_global(8'h39) |=> st_ff.data == 8'h01) // R05
		else $error("wakeup threshold low byte wrong");
	AST_MIN_LPI: assert property (s_trig_global(8'h36) or s_trig_global(8'h37) // R06
		|=> st_ff.data == 8'h00)
		else $error("min_lpi_cycles_control register not zero");
	AST_PCS_DIAG: assert property (s_trig_global(8'h3B) |=> st_ff.data == 8'h01) // R07
		else $error("PCS diagnostic low byte wrong");
	AST_PCS_DIAG_HI: assert property (s_trig_global(8'h3A) |=> st_ff.data == 8'h00) // R07
		else $error("PCS diagnostic high byte wrong");
	AST_EXP_HI: assert property (s_trig_port(8'h0C) |=> st_ff.data == 8'h00) // R08
		else $error("expansion status reserved byte not zero");
	AST_EXP_FIXED: assert property (s_trig_port(8'h0D) // R09
		|=> st_ff.data[6] && st_ff.data[5] && st_ff.data[2] && !st_ff.data[7])
		else $error("expansion status fixed bits wrong");
	AST_EXP_LIVE: assert property (s_trig_port(8'h0D) // R02
		|=> st_ff.data == $past(port_status[port_idx][7:0]))
		else $error("expansion status byte not from selected port");
	AST_NO_SPACE: assert property (ofs_wr && !eee_global && !eee_port // R16
		|=> st_ff.data == 8'h00)
		else $error("unmapped target returned data");
	AST_RO_WRITE: assert property (data_wr && eee_space && !ofs_wr // R18
		|=> $stable(st_ff.data))
		else $error("write changed a read-only EEE byte");
	AST_READ_BACK: assert property (s_trig_global(8'h38) ##1 s_idle_data ##1 s_read_data // R03
		|=> rvalid_o && rdata_o == 8'h02)
		else $error("indirect byte register did not return fetched data");
	AST_CLR_PULSE: assert property (s_trig_port(8'h0D) |-> $onehot(port_rd_clr)) // R11
		else $error("clear on read not sent to one port");

	AST_RVALID_SET: assert property (req_i.rd // R03
		|=> rvalid_o)
		else $error("read not answered one cycle later");
	AST_RVALID_DROP: assert property (!req_i.rd // R03
		|=> !rvalid_o)
		else $error("read valid without a read");
	AST_RDATA_HOLD: assert property (!req_i.rd // R03
		|=> $stable(rdata_o))
		else $error("read data changed without a read");

	AST_READ_SEL: assert property (s_read_at(EIB_SEL_ADDR) // R17
		|=> rdata_o == $past(st_ff.sel))
		else $error("select register read back wrong");
	AST_READ_OFS: assert property (s_read_at(EIB_OFS_ADDR) // R03
		|=> rdata_o == $past(st_ff.ofs))
		else $error("offset register read back wrong");
	AST_READ_DATA: assert property (s_read_at(EIB_DATA_ADDR) // R03
		|=> rdata_o == $past(st_ff.data))
		else $error("data register read back wrong");
	AST_READ_UNMAPPED: assert property (req_i.rd && req_i.addr != EIB_SEL_ADDR // R03
		&& req_i.addr != EIB_OFS_ADDR && req_i.addr != EIB_DATA_ADDR |=> rdata_o == 8'h00)
		else $error("unmapped address returned data");

	AST_SEL_STORE: assert property (sel_wr // R17
		|=> st_ff.sel == $past(req_i.wdata))
		else $error("select write not stored");
	AST_SEL_KEEP: assert property (!sel_wr // R17
		|=> $stable(st_ff.sel))
		else $error("select changed without a write");
	AST_OFS_STORE: assert property (ofs_wr // R03
		|=> st_ff.ofs == $past(req_i.wdata))
		else $error("offset write not stored");
	AST_OFS_KEEP: assert property (!ofs_wr // R03
		|=> $stable(st_ff.ofs))
		else $error("offset changed without a write");

	AST_DATA_KEEP: assert property (s_idle_data // R17
		|=> $stable(st_ff.data))
		else $error("data byte changed without a trigger");
	AST_DATA_FOREIGN: assert property (data_wr && !eee_space // R03
		|=> st_ff.data == $past(req_i.wdata))
		else $error("data write outside EEE space not stored");
	AST_SPACE_OTHER: assert property (ofs_wr && st_ff.sel[7:5] != EIB_SPACE_EEE // R01
		|=> st_ff.data == 8'h00)
		else $error("other space returned data");
	AST_TGT_HIGH: assert property (ofs_wr && eee_space && st_ff.sel[3:0] > EIB_PORT_LAST // R02
		|=> st_ff.data == 8'h00)
		else $error("target above last port returned data");

	AST_CLR_IDLE: assert property (!ofs_wr // R14
		|-> port_rd_clr == '0)
		else $error("clear on read without a trigger");
	AST_CLR_HIGH_BYTE: assert property (s_trig_port(8'h0C) // R11
		|-> port_rd_clr == '0)
		else $error("high byte fetch cleared status");
	AST_CLR_TARGET: assert property (s_trig_port(8'h0D) // R02
		|-> port_rd_clr[port_idx])
		else $error("clear on read sent to wrong port");
	AST_CLR_GLOBAL: assert property (ofs_wr && !eee_port // R16
		|-> port_rd_clr == '0)
		else $error("non-port fetch cleared status");
	AST_CLR_ONE: assert property (ofs_wr // R11
		|-> $onehot0(port_rd_clr))
		else $error("clear on read sent to several ports");

	AST_EXP_LOC8H: assert property (s_trig_port(8'h0D) // R10
		|=> st_ff.data[EIB_BIT_LOC_8H])
		else $error("next page location bit not set");
	AST_EXP_NP: assert property (s_trig_port(8'h0D) // R13
		|=> st_ff.data[EIB_BIT_NP_ABLE])
		else $error("local next page ability bit not set");
	AST_EXP_PAGE: assert property (s_trig_port(8'h0D) // R14
		|=> st_ff.data[EIB_BIT_PAGE_RX] == $past(port_status[port_idx][EIB_BIT_PAGE_RX]))
		else $error("page received bit not from selected port");

	AST_EXP_RB: assert property (s_trig_port(8'h0C) ##1 s_idle_data ##1 s_read_data // R08
		|=> rvalid_o && rdata_o == 8'h00)
		else $error("expansion status high byte read back wrong");
	AST_WAKE_LO_RB: assert property (s_trig_global(8'h39) ##1 s_idle_data ##1 s_read_data // R05
		|=> rvalid_o && rdata_o == 8'h01)
		else $error("wakeup threshold low byte read back wrong");
	AST_PCS_RB: assert property (s_trig_global(8'h3B) ##1 s_idle_data ##1 s_read_data // R07
		|=> rvalid_o && rdata_o == 8'h01)
		else $error("PCS diagnostic low byte read back wrong");
	AST_MIN_LPI_RB: assert property (s_trig_global(8'h36) ##1 s_idle_data ##1 s_read_data // R06
		|=> rvalid_o && rdata_o == 8'h00)
		else $error("min_lpi_cycles_control byte read back wrong");
	AST_PORT_RB_LO: assert property (s_trig_port(8'h0D) ##1 s_idle_data ##1 s_read_data // R10
		|=> rdata_o[EIB_BIT_LOC_ABLE] && rdata_o[EIB_BIT_LOC_8H] && rdata_o[EIB_BIT_NP_ABLE])
		else $error("expansion status low byte read back wrong");

endmodule // eib_bank

//--- test/eib_host_model.sv
`timescale 1ns/1ps
module eib_host_model (
	input wire logic clk_i,
	output eib_pkg::eib_req_type req_o,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i
);
	import eib_pkg::*;

	initial req_o = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_i);
		req_o = '{1'b1, 1'b0, a, v};
		@(negedge clk_i);
		req_o = '0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		v = 8'hxx;
		@(negedge clk_i);
		req_o = '{1'b0, 1'b1, a, 8'h00};
		for (int i = 0; i < 3; i++) begin
			@(negedge clk_i);
			req_o = '0;
			if (rvalid_i === 1'b1) begin
				v = rdata_i;
			end
		end
	endtask

	// Select goes first; the offset write then starts the fetch into the data byte.
	task automatic fetch(input logic [7:0] sel, input logic [7:0] ofs, output logic [7:0] v);
		wr(EIB_SEL_ADDR, sel);
		wr(EIB_OFS_ADDR, ofs);
		rd(EIB_DATA_ADDR, v);
	endtask
endmodule // eib_host_model

//--- test/eib_bank_tb_top.sv
`timescale 1ns/1ps
module eib_bank_tb_top;
	import eib_pkg::*;

	logic clk_i;
	logic srst_i;
	eib_req_type req;
	logic [7:0] rdata;
	logic rvalid;
	eib_phy_type [EIB_NUM_PORTS-1:0] phy;
	logic [EIB_NUM_PORTS-1:0][15:0] werr;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] d;

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	eib_bank u_eib_bank (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.req_i(req),
		.rdata_o(rdata),
		.rvalid_o(rvalid),
		.phy_i(phy),
		.wake_err_cnt_o(werr)
	);

	eib_host_model u_eib_host_model (
		.clk_i(clk_i),
		.req_o(req),
		.rdata_i(rdata),
		.rvalid_i(rvalid)
	);

	task automatic give_verdict;
		if (miscompares == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict;
		end
	end

	task automatic t_global;
		logic [7:0] ofs [6] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B};
		logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h01};
		for (int i = 0; i < 6; i++) begin
			u_eib_host_model.fetch(8'h20, ofs[i], d);
			chk("global byte", {8'h00, exp[i]}, {8'h00, d});
		end
		u_eib_host_model.fetch(8'h20, 8'h38, d);
		u_eib_host_model.wr(EIB_DATA_ADDR, 8'h55);
		u_eib_host_model.rd(EIB_DATA_ADDR, d);
		chk("data after write", 16'h0002, {8'h00, d});
		u_eib_host_model.fetch(8'h20, 8'h38, d);
		chk("threshold refetch", 16'h0002, {8'h00, d});
	endtask

	task automatic t_routing;
		for (int p = 1; p <= 4; p++) begin
			u_eib_host_model.fetch(8'h20 | 8'(p), 8'h0C, d);
			chk("status high", 16'h0000, {8'h00, d});
			u_eib_host_model.fetch(8'h20 | 8'(p), 8'h0D, d);
			chk("status low", 16'h0064, {8'h00, d});
		end
		u_eib_host_model.fetch(8'h25, 8'h0D, d);
		chk("target five", 16'h0000, {8'h00, d});
		u_eib_host_model.fetch(8'h40, 8'h38, d);
		chk("other space", 16'h0000, {8'h00, d});
		u_eib_host_model.rd(EIB_SEL_ADDR, d);
		chk("select readback", 16'h0040, {8'h00, d});
		u_eib_host_model.rd(EIB_OFS_ADDR, d);
		chk("offset readback", 16'h0038, {8'h00, d});
		u_eib_host_model.wr(EIB_DATA_ADDR, 8'h5A);
		u_eib_host_model.rd(EIB_DATA_ADDR, d);
		chk("foreign data", 16'h005A, {8'h00, d});
		u_eib_host_model.rd(8'h10, d);
		chk("unmapped read", 16'h0000, {8'h00, d});
	endtask

	task automatic t_events;
		@(negedge clk_i);
		phy[1].pd_fault = 1'b1;
		phy[1].page_rx = 1'b1;
		phy[1].lp_np_able = 1'b1;
		phy[1].lp_an_able = 1'b1;
		@(negedge clk_i);
		phy[1].pd_fault = 1'b0;
		phy[1].page_rx = 1'b0;
		repeat (2) @(negedge clk_i);
		u_eib_host_model.fetch(8'h22, 8'h0C, d);
		chk("event high", 16'h0000, {8'h00, d});
		u_eib_host_model.fetch(8'h22, 8'h0D, d);
		chk("event low", 16'h007F, {8'h00, d});
		u_eib_host_model.fetch(8'h22, 8'h0D, d);
		chk("after clear", 16'h006D, {8'h00, d});
		u_eib_host_model.fetch(8'h21, 8'h0D, d);
		chk("other port", 16'h0064, {8'h00, d});
	endtask

	task automatic t_wake;
		@(negedge clk_i);
		phy[0].wake_start = 1'b1;
		@(negedge clk_i);
		phy[0].wake_start = 1'b0;
		repeat (600) @(negedge clk_i);
		phy[0].wake_done = 1'b1;
		phy[2].wake_start = 1'b1;
		@(negedge clk_i);
		phy[0].wake_done = 1'b0;
		phy[2].wake_start = 1'b0;
		repeat (100) @(negedge clk_i);
		phy[2].wake_done = 1'b1;
		@(negedge clk_i);
		phy[2].wake_done = 1'b0;
		repeat (2) @(negedge clk_i);
		chk("slow wakeup", 16'h0001, werr[0]);
		chk("fast wakeup", 16'h0000, werr[2]);
		chk("idle wakeups", 16'h0000, werr[1] | werr[3]);
	endtask

	initial begin
		srst_i = 1'b1;
		phy = '0;
		repeat (3) @(negedge clk_i);
		srst_i = 1'b0;
		t_global;
		t_routing;
		t_events;
		t_wake;
		give_verdict;
	end
endmodule // eib_bank_tb_top
